// >>> core/spdrx_err_status.sv
// Operation
// - High preamble register shows upper byte of detected Preamble-D, else zero.
// - Low preamble register shows lower byte of detected Preamble-D, else zero.
// - Subframe nonaudio mode reports Channel B Preamble-C in that register pair.
// - Read-only receiver fault status register holds eight flags, validity down to lock.
// - Bit 7 follows the received validity bit directly.
// - Bit 6 shows pre-emphasis; after a read it asks again only on change.
// - Bit 5 shows nonaudio status; re-asks on return to audio or type change.
// - Bit 4 shows nonaudio preamble found; after a read re-asks only on change.
// - Bit 3 checksum fault is held until the status register is read.
// - Bit 2 shows stream absent; after a read re-asks only on change.
// - Bit 1 coding or parity fault is held until the status register is read.
// - Bit 0 shows PLL lock; after a read re-asks only on change.
// - Writable enable register, one bit per flag; 1 lets it interrupt.
// - Read-only converter register: too slow, left clip, right clip, mute; top reserved.
// - Any enabled receiver request sets summary bit, held until interrupt status register is read.
// - Left and right clip flags are held until converter register is read.
`timescale 1ns/1ps
module spdrx_err_status (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire spdrx_pkg::spdrx_rx_in_t  rx_in,
  input  wire logic                     nonaudio_type_chg,
  input  wire spdrx_pkg::spdrx_cv_in_t  cv_in,
  input  wire spdrx_pkg::spdrx_pre_in_t pre_in,
  input  wire logic [spdrx_pkg::AW-1:0] reg_addr,
  input  wire logic                     reg_rd,
  input  wire logic                     reg_wr,
  input  wire logic [spdrx_pkg::DW-1:0] reg_wdata,
  output logic [spdrx_pkg::DW-1:0]      reg_rdata,
  output logic                          reg_rvalid,
  output logic                          receiver_fault_summary
);

  logic [7:0]  rx_vec;
  logic [7:0]  rx_flag;
  logic [7:0]  rx_pend;
  logic [7:0]  rx_retrig;
  logic [3:0]  cv_vec;
  logic [3:0]  cv_flag;
  logic [15:0] pre_word;
  logic        rd_rx;
  logic        rd_cv;
  logic        rd_irq;

  logic [7:0] enable_r;
  logic [7:0] enable_nxt;
  logic       summary_r;
  logic       summary_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;

  assign rx_vec = rx_in;
  assign cv_vec = cv_in;
  assign rd_rx  = reg_rd && (reg_addr == spdrx_pkg::ADDR_RX_STATUS);
  assign rd_cv  = reg_rd && (reg_addr == spdrx_pkg::ADDR_CONV_STAT);
  assign rd_irq = reg_rd && (reg_addr == spdrx_pkg::ADDR_IRQ_STATUS);

  // A new kind of nonaudio data re-arms the nonaudio request while it stays set
  always_comb begin
    rx_retrig = 8'h00;
    rx_retrig[spdrx_pkg::BIT_NONAUDIO] = nonaudio_type_chg & rx_in.nonaudio;
  end

  // Validity is live too; its request follows the same change rule as the other live flags
  for (genvar i = 0; i < 8; i++) begin : g_rx
    spdrx_flag_cell #(
      .STICKY (spdrx_pkg::RX_STICKY_BITS[i])
    ) u_cell (
      .clk    (clk),
      .rst    (rst),
      .live   (rx_vec[i]),
      .retrig (rx_retrig[i]),
      .rd_clr (rd_rx),
      .flag   (rx_flag[i]),
      .pend   (rx_pend[i])
    );
  end

  // Converter requests are not routed anywhere here, so pend is left open
  for (genvar j = 0; j < 4; j++) begin : g_cv
    spdrx_flag_cell #(
      .STICKY (spdrx_pkg::CV_STICKY_BITS[j])
    ) u_cell (
      .clk    (clk),
      .rst    (rst),
      .live   (cv_vec[j]),
      .retrig (1'b0),
      .rd_clr (rd_cv),
      .flag   (cv_flag[j]),
      .pend   ()
    );
  end

  spdrx_preamble_sel u_pre (
    .clk      (clk),
    .rst      (rst),
    .pre_in   (pre_in),
    .pre_word (pre_word)
  );

  always_comb begin
    enable_nxt = enable_r;
    if (reg_wr && (reg_addr == spdrx_pkg::ADDR_RX_ENABLE)) begin
      enable_nxt = reg_wdata;
    end
    // Set wins over the read clear of the summary bit
    summary_nxt = (|(rx_pend & enable_r)) | (summary_r & ~rd_irq);
  end

  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        spdrx_pkg::ADDR_PRE_HIGH:   rdata_nxt = pre_word[15:8];
        spdrx_pkg::ADDR_PRE_LOW:    rdata_nxt = pre_word[7:0];
        spdrx_pkg::ADDR_RX_STATUS:  rdata_nxt = rx_flag;
        spdrx_pkg::ADDR_RX_ENABLE:  rdata_nxt = enable_r;
        spdrx_pkg::ADDR_CONV_STAT:  rdata_nxt = {4'h0, cv_flag} & spdrx_pkg::CV_USED_BITS;
        spdrx_pkg::ADDR_IRQ_STATUS: rdata_nxt = {7'h00, summary_r};
        default:                    rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_r  <= spdrx_pkg::RX_ENABLE_RST;
      summary_r <= 1'b0;
      rdata_r   <= 8'h00;
      rvalid_r  <= 1'b0;
    end else begin
      enable_r  <= enable_nxt;
      summary_r <= summary_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
    end
  end

  assign reg_rdata              = rdata_r;
  assign reg_rvalid             = rvalid_r;
  assign receiver_fault_summary = summary_r;

endmodule

// >>> core/spdrx_flag_cell.sv
`timescale 1ns/1ps
module spdrx_flag_cell #(
  parameter bit STICKY = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic live,
  input  wire logic retrig,
  input  wire logic rd_clr,
  output logic      flag,
  output logic      pend
);

  logic state_r;
  logic state_nxt;
  logic rearm_r;
  logic rearm_nxt;

  always_comb begin
    if (STICKY) begin
      // Set wins over the read clear so a pulse in the read cycle survives
      state_nxt = live | (state_r & ~rd_clr);
      rearm_nxt = 1'b0;
    end else begin
      // Remember what software saw; a difference or a retrigger asks again
      state_nxt = rd_clr ? live : state_r;
      rearm_nxt = retrig | (rearm_r & ~rd_clr);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= 1'b0;
      rearm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rearm_r <= rearm_nxt;
    end
  end

  assign flag = STICKY ? state_r : live;
  assign pend = STICKY ? state_r : ((live ^ state_r) | rearm_r);

endmodule

// >>> core/spdrx_preamble_sel.sv
`timescale 1ns/1ps
module spdrx_preamble_sel (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire spdrx_pkg::spdrx_pre_in_t pre_in,
  output logic [15:0]                 pre_word
);

  logic [15:0] word_r;
  logic [15:0] word_nxt;

  always_comb begin
    if (!pre_in.nonaudio_det) begin
      word_nxt = 16'h0000;
    end else if (pre_in.subframe_mode) begin
      word_nxt = pre_in.preamble_c_chan_b;
    end else begin
      word_nxt = pre_in.preamble_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_r <= 16'h0000;
    end else begin
      word_r <= word_nxt;
    end
  end

  assign pre_word = word_r;

endmodule

// >>> inc/spdrx_pkg.sv
package spdrx_pkg;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;

  localparam logic [7:0] ADDR_PRE_HIGH   = 8'h16;
  localparam logic [7:0] ADDR_PRE_LOW    = 8'h17;
  localparam logic [7:0] ADDR_RX_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_RX_ENABLE  = 8'h19;
  localparam logic [7:0] ADDR_CONV_STAT  = 8'h1A;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;

  localparam logic [7:0] RX_ENABLE_RST  = 8'h00;
  localparam logic [7:0] RX_STICKY_BITS = 8'h0A;
  localparam logic [7:0] CV_STICKY_BITS = 8'h06;
  localparam logic [7:0] CV_USED_BITS   = 8'h0F;
  localparam int unsigned BIT_NONAUDIO  = 5;
  localparam int unsigned BIT_SUMMARY   = 0;

  // Bit order matches the receiver fault status register, bit 7 first
  typedef struct packed {
    logic valid;
    logic emphasis;
    logic nonaudio;
    logic nonaudio_pre;
    logic crc_fault_pulse;
    logic stream_absent;
    logic coding_fault_pulse;
    logic pll_lock;
  } spdrx_rx_in_t;

  // Bit order matches the low nibble of the rate converter status register
  typedef struct packed {
    logic too_slow;
    logic left_clip_pulse;
    logic right_clip_pulse;
    logic mute_hint;
  } spdrx_cv_in_t;

  typedef struct packed {
    logic        nonaudio_det;
    logic        subframe_mode;
    logic [15:0] preamble_d;
    logic [15:0] preamble_c_chan_b;
  } spdrx_pre_in_t;

endpackage

// >>> testbench/spdrx_err_status_asserts.sv
`timescale 1ns/1ps
module spdrx_err_status_asserts (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire spdrx_pkg::spdrx_rx_in_t  rx_in,
  input wire spdrx_pkg::spdrx_pre_in_t pre_in,
  input wire logic [spdrx_pkg::AW-1:0] reg_addr,
  input wire logic                     reg_rd,
  input wire logic                     reg_wr,
  input wire logic [spdrx_pkg::DW-1:0] reg_wdata,
  input wire logic [spdrx_pkg::DW-1:0] reg_rdata,
  input wire logic                     receiver_fault_summary
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire r18 = reg_rd && reg_addr == 8'h18;
  wire r19 = reg_rd && reg_addr == 8'h19;
  wire w19 = reg_wr && reg_addr == 8'h19;
  wire r16 = reg_rd && reg_addr == 8'h16;
  wire r1a = reg_rd && reg_addr == 8'h1A;
  wire r1c = reg_rd && reg_addr == 8'h1C;
  property p_vld; r18 |=> reg_rdata[7] == $past(rx_in.valid); endproperty
  a_vld: assert property (p_vld) else $error("validity bit wrong");
  property p_cres; r1a |=> reg_rdata[7:4] == 4'h0; endproperty
  a_cres: assert property (p_cres) else $error("reserved bits set");
  property p_sum; receiver_fault_summary && !r1c |=> receiver_fault_summary; endproperty
  a_sum: assert property (p_sum) else $error("summary dropped early");
  property p_pre; r16 && !$past(pre_in.nonaudio_det) |=> reg_rdata == 8'h00; endproperty
  a_pre: assert property (p_pre) else $error("preamble not zero");
  property p_crc; rx_in.crc_fault_pulse ##1 !r18 ##1 r18 |=> reg_rdata[3]; endproperty
  a_crc: assert property (p_crc) else $error("checksum flag lost");
  property p_cod; rx_in.coding_fault_pulse ##1 !r18 ##1 r18 |=> reg_rdata[1]; endproperty
  a_cod: assert property (p_cod) else $error("coding flag lost");
  property p_clr;
    r18 && !rx_in.crc_fault_pulse ##1 !rx_in.crc_fault_pulse ##1 r18 |=> !reg_rdata[3];
  endproperty
  a_clr: assert property (p_clr) else $error("checksum flag not cleared");
  property p_en; w19 ##1 !reg_wr ##1 r19 |=> reg_rdata == $past(reg_wdata, 3); endproperty
  a_en: assert property (p_en) else $error("enable readback wrong");
endmodule
bind spdrx_err_status spdrx_err_status_asserts u_chk (.clk(clk), .rst(rst), .rx_in(rx_in),
  .pre_in(pre_in), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .receiver_fault_summary(receiver_fault_summary));

// >>> testbench/spdrx_err_status_tb.sv
`timescale 1ns/1ps
module spdrx_err_status_tb;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  spdrx_pkg::spdrx_rx_in_t  want = '0;
  spdrx_pkg::spdrx_rx_in_t  rx_in;
  spdrx_pkg::spdrx_cv_in_t  cv_in = '0;
  spdrx_pkg::spdrx_pre_in_t pre_in = '0;
  logic [7:0]               addr = 8'h00;
  logic [7:0]               wdata = 8'h00;
  logic [7:0]               rdata;
  logic                     rd = 1'b0;
  logic                     wr = 1'b0;
  logic                     type_chg = 1'b0;
  logic                     rvalid;
  logic                     summ;
  int                       bad_count = 0;
  int                       checks_done = 0;
  int                       cyc = 0;
  always #20 clk = ~clk;
  spdrx_stream_src u_src (.want(want), .rx_in(rx_in));
  spdrx_err_status u_dut (.clk(clk), .rst(rst), .rx_in(rx_in), .nonaudio_type_chg(type_chg),
    .cv_in(cv_in), .pre_in(pre_in), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .receiver_fault_summary(summ));
  task automatic close_out;
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01, "read valid");
    chk(rdata, exp, "read data");
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Generous ceiling; the sequence needs well under 200 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rdr(8'h19, 8'h00);
    rdr(8'h30, 8'h00);
    wrr(8'h19, 8'h40);
    wrr(8'h18, 8'hFF);
    rdr(8'h19, 8'h40);
    rdr(8'h18, 8'h00);
    pre_in.preamble_d = 16'hA55A;
    pre_in.preamble_c_chan_b = 16'hC33C;
    rdr(8'h16, 8'h00);
    pre_in.nonaudio_det = 1'b1;
    rdr(8'h16, 8'hA5);
    rdr(8'h17, 8'h5A);
    pre_in.subframe_mode = 1'b1;
    rdr(8'h16, 8'hC3);
    rdr(8'h17, 8'h3C);
    want.valid = 1'b1;
    want.pll_lock = 1'b1;
    want.emphasis = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h00, summ}, 8'h01, "summary");
    rdr(8'h18, 8'hC1);
    rdr(8'h1C, 8'h01);
    rdr(8'h1C, 8'h00);
    chk({7'h00, summ}, 8'h00, "summary");
    wrr(8'h19, 8'h45);
    rdr(8'h19, 8'h45);
    want.stream_absent = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h00, summ}, 8'h01, "summary");
    rdr(8'h18, 8'h44);
    rdr(8'h1C, 8'h01);
    rdr(8'h1C, 8'h00);
    want.stream_absent = 1'b0;
    want.crc_fault_pulse = 1'b1;
    want.coding_fault_pulse = 1'b1;
    @(negedge clk);
    want.crc_fault_pulse = 1'b0;
    want.coding_fault_pulse = 1'b0;
    rdr(8'h18, 8'hCB);
    rdr(8'h18, 8'hC1);
    cv_in = 4'hE;
    @(negedge clk);
    cv_in = 4'h8;
    rdr(8'h1A, 8'h0E);
    cv_in = 4'h1;
    rdr(8'h1A, 8'h01);
    wrr(8'h19, 8'h30);
    rdr(8'h1C, 8'h01);
    want.nonaudio = 1'b1;
    want.nonaudio_pre = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h00, summ}, 8'h01, "summary");
    rdr(8'h18, 8'hF1);
    rdr(8'h1C, 8'h01);
    rdr(8'h1C, 8'h00);
    // A new kind of nonaudio data must ask again although the flag stays set
    type_chg = 1'b1;
    @(negedge clk);
    type_chg = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, summ}, 8'h01, "summary");
    rdr(8'h18, 8'hF1);
    rdr(8'h1C, 8'h01);
    rdr(8'h1C, 8'h00);
    want.nonaudio = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, summ}, 8'h01, "summary");
    close_out;
  end
endmodule

// >>> testbench/spdrx_stream_src.sv
`timescale 1ns/1ps
module spdrx_stream_src (
  input wire spdrx_pkg::spdrx_rx_in_t want,
  output spdrx_pkg::spdrx_rx_in_t     rx_in
);
  // A missing stream can hold neither lock nor a valid flag
  always_comb begin
    rx_in = want;
    if (want.stream_absent) begin
      rx_in.pll_lock = 1'b0;
      rx_in.valid = 1'b0;
    end
  end
endmodule
